// File: design/laser_shutdown_soak_ber_control.sv
// What this block does
// - After reset the shutdown mode is disabled and the laser stays on despite loss.
// - Auto mode turns the laser off on loss and back on when it clears.
// - Manual mode turns off on loss and stays off until a restart command given after the loss has cleared.
// - Test mode lets a restart command turn the laser on for testing.
// - Armed soak moves the port in service after continuous valid input for the duration.
// - Soak duration spans zero to 48 hours in 15-minute steps only.
// - Framed traffic only: signal-fail threshold selectable as 1E-3, 1E-4 or 1E-5.
// - Framed traffic only: signal-degrade threshold selectable as 1E-5, 1E-6 or 1E-7.
//
// The address map and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "laser_soak_regs.svh"

module laser_shutdown_soak_ber_control
  import laser_soak_pkg::*;
#(
  parameter longint unsigned STEP_CYCLES =
    64'(`SOAK_STEP_MINUTES) * 64'd60 * 64'd1000000 * 64'(`CLK_MHZ)
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // Line side
  input wire logic i_signal_loss,
  input wire logic [3:0] i_ber_exp,
  output logic o_laser_on,
  output logic o_in_service,
  output logic o_signal_fail,
  output logic o_signal_degrade,
  output logic o_irq,
  // AXI4-Lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [1:0] clamp_sel(input logic [1:0] sel);
    clamp_sel = (sel > `SEL_MAX) ? `SEL_MAX : sel;
  endfunction : clamp_sel
  function automatic logic [3:0] sel_exp(input logic [3:0] base, input logic [1:0] sel);
    sel_exp = base + {2'h0, sel};
  endfunction : sel_exp
  function automatic logic mapped(input logic [7:0] addr);
    mapped = (addr == `REG_CTRL) || (addr == `REG_SOAK) || (addr == `REG_CMD) ||
             (addr == `REG_STATUS) || (addr == `REG_IRQ_STAT) || (addr == `REG_IRQ_MASK);
  endfunction : mapped
  ////////////////////////////////////////////////////////////////////////////
  // State
  logic loss_meta_q, loss_sync_q, loss_prev_q;
  ctrl_type ctrl_q, ctrl_d;
  logic [7:0] soak_steps_q, soak_steps_d;
  logic restart_q, restart_d;
  laser_state_type laser_q, laser_d;
  logic in_service_q, in_service_d;
  logic [39:0] tick_q, tick_d;
  logic [7:0] step_q, step_d;
  logic sf_q, sf_d, sd_q, sd_d;
  logic [3:0] irq_stat_q, irq_stat_d, irq_mask_q, irq_mask_d, events;
  logic irq_q, irq_d;
  logic [7:0] awaddr_q, awaddr_d;
  logic aw_have_q, aw_have_d, w_have_q, w_have_d;
  logic [31:0] wdata_q, wdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  logic do_write, wr_lo;
  status_type status;
  ////////////////////////////////////////////////////////////////////////////
  // Bus and registers
  assign s_axi_awready = !aw_have_q;
  assign s_axi_wready = !w_have_q;
  assign s_axi_arready = !rvalid_q;
  assign do_write = aw_have_q && w_have_q && !bvalid_q;
  assign wr_lo = do_write && wstrb_q[0];
  assign status = '{sd: sd_q, sf: sf_q, loss: loss_sync_q,
                    in_service: in_service_q, laser_on: laser_q};
  assign events = {sd_d && !sd_q, sf_d && !sf_q, in_service_d && !in_service_q,
                   loss_sync_q && !loss_prev_q};

  always_comb begin
    awaddr_d = awaddr_q;
    aw_have_d = aw_have_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    w_have_d = w_have_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    ctrl_d = ctrl_q;
    soak_steps_d = soak_steps_q;
    restart_d = 1'b0;
    irq_mask_d = irq_mask_q;
    irq_stat_d = irq_stat_q;
    if (s_axi_awvalid && !aw_have_q) begin
      awaddr_d = s_axi_awaddr;
      aw_have_d = 1'b1;
    end
    if (s_axi_wvalid && !w_have_q) begin
      wdata_d = s_axi_wdata;
      wstrb_d = s_axi_wstrb;
      w_have_d = 1'b1;
    end
    if (do_write) begin
      aw_have_d = 1'b0;
      w_have_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = mapped(awaddr_q) ? 2'b00 : 2'b10;
    end else if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    if (wr_lo && awaddr_q == `REG_CTRL) begin
      ctrl_d = ctrl_type'(wdata_q[7:0]);
      ctrl_d.sf_sel = clamp_sel(wdata_q[5:4]);
      ctrl_d.sd_sel = clamp_sel(wdata_q[7:6]);
    end
    if (wr_lo && awaddr_q == `REG_SOAK) begin
      soak_steps_d = (wdata_q[7:0] > 8'(`SOAK_MAX_STEPS)) ? 8'(`SOAK_MAX_STEPS)
                                                          : wdata_q[7:0];
    end
    if (wr_lo && awaddr_q == `REG_CMD) begin
      restart_d = wdata_q[`CMD_RESTART_BIT];
    end
    if (wr_lo && awaddr_q == `REG_IRQ_MASK) begin
      irq_mask_d = wdata_q[3:0];
    end
    if (wr_lo && awaddr_q == `REG_IRQ_STAT) begin
      irq_stat_d = irq_stat_q & ~wdata_q[3:0];
    end
    irq_stat_d = irq_stat_d | events;
    irq_d = |(irq_stat_d & irq_mask_d);
    if (s_axi_arvalid && !rvalid_q) begin
      rvalid_d = 1'b1;
      rresp_d = mapped(s_axi_araddr) ? 2'b00 : 2'b10;
      unique case (s_axi_araddr)
        `REG_CTRL: rdata_d = {24'h0, ctrl_q};
        `REG_SOAK: rdata_d = {24'h0, soak_steps_q};
        `REG_STATUS: rdata_d = {27'h0, status};
        `REG_IRQ_STAT: rdata_d = {28'h0, irq_stat_q};
        `REG_IRQ_MASK: rdata_d = {28'h0, irq_mask_q};
        default: rdata_d = 32'h0;
      endcase
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Laser shutdown
  always_comb begin
    laser_d = laser_q;
    unique case (ctrl_q.mode)
      MODE_DISABLED: laser_d = LASER_ON;
      MODE_AUTO: laser_d = loss_sync_q ? LASER_OFF : LASER_ON;
      MODE_MANUAL: begin
        if (loss_sync_q) begin
          laser_d = LASER_OFF;
        end else if (restart_q) begin
          laser_d = LASER_ON;
        end
      end
      MODE_TEST: begin
        if (restart_q) begin
          laser_d = LASER_ON;
        end
      end
    endcase
  end
  ////////////////////////////////////////////////////////////////////////////
  // In-service soak
  always_comb begin
    tick_d = tick_q;
    step_d = step_q;
    in_service_d = in_service_q;
    if (!ctrl_q.soak_arm) begin
      tick_d = 40'h0;
      step_d = 8'h0;
      in_service_d = 1'b0;
    end else if (!in_service_q) begin
      if (loss_sync_q) begin
        tick_d = 40'h0;
        step_d = 8'h0;
      end else if (step_q >= soak_steps_q) begin
        in_service_d = 1'b1;
      end else if (tick_q == 40'(STEP_CYCLES - 64'd1)) begin
        tick_d = 40'h0;
        step_d = step_q + 8'h1;
      end else begin
        tick_d = tick_q + 40'h1;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Error-rate thresholds
  always_comb begin
    sf_d = ctrl_q.framed && (i_ber_exp != 4'h0) &&
           (i_ber_exp <= sel_exp(`SF_BASE_EXP, ctrl_q.sf_sel));
    sd_d = ctrl_q.framed && (i_ber_exp != 4'h0) &&
           (i_ber_exp <= sel_exp(`SD_BASE_EXP, ctrl_q.sd_sel));
  end
  ////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      loss_meta_q <= 1'b0;
      loss_sync_q <= 1'b0;
      loss_prev_q <= 1'b0;
      ctrl_q <= ctrl_type'(`CTRL_RESET);
      soak_steps_q <= `SOAK_RESET;
      restart_q <= 1'b0;
      laser_q <= LASER_ON;
      in_service_q <= 1'b0;
      tick_q <= 40'h0;
      step_q <= 8'h0;
      sf_q <= 1'b0;
      sd_q <= 1'b0;
      irq_stat_q <= 4'h0;
      irq_mask_q <= `IRQ_MASK_RESET;
      irq_q <= 1'b0;
      awaddr_q <= 8'h0;
      aw_have_q <= 1'b0;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
      w_have_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= 2'h0;
      rvalid_q <= 1'b0;
      rresp_q <= 2'h0;
      rdata_q <= 32'h0;
    end else begin
      loss_meta_q <= i_signal_loss;
      loss_sync_q <= loss_meta_q;
      loss_prev_q <= loss_sync_q;
      ctrl_q <= ctrl_d;
      soak_steps_q <= soak_steps_d;
      restart_q <= restart_d;
      laser_q <= laser_d;
      in_service_q <= in_service_d;
      tick_q <= tick_d;
      step_q <= step_d;
      sf_q <= sf_d;
      sd_q <= sd_d;
      irq_stat_q <= irq_stat_d;
      irq_mask_q <= irq_mask_d;
      irq_q <= irq_d;
      awaddr_q <= awaddr_d;
      aw_have_q <= aw_have_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      w_have_q <= w_have_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
    end
  end
  assign o_laser_on = laser_q;
  assign o_in_service = in_service_q;
  assign o_signal_fail = sf_q;
  assign o_signal_degrade = sd_q;
  assign o_irq = irq_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;
  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  property p_disabled_on;
    ctrl_q.mode == MODE_DISABLED |=> o_laser_on;
  endproperty
  a_disabled_on: assert property (p_disabled_on) else $error("laser off in disabled mode");
  property p_auto_follow;
    ctrl_q.mode == MODE_AUTO |=> (o_laser_on == !$past(loss_sync_q));
  endproperty
  a_auto_follow: assert property (p_auto_follow) else $error("auto mode laser wrong");
  property p_manual_hold;
    ctrl_q.mode == MODE_MANUAL && !o_laser_on && !restart_q |=> !o_laser_on;
  endproperty
  a_manual_hold: assert property (p_manual_hold) else $error("manual laser came back");
  property p_test_restart;
    ctrl_q.mode == MODE_TEST && restart_q |=> o_laser_on;
  endproperty
  a_test_restart: assert property (p_test_restart) else $error("test restart ignored");
  property p_soak_done;
    ctrl_q.soak_arm && !in_service_q && !loss_sync_q && step_q >= soak_steps_q |=> o_in_service;
  endproperty
  a_soak_done: assert property (p_soak_done) else $error("soak did not complete");
  property p_soak_range;
    soak_steps_q <= 8'(`SOAK_MAX_STEPS);
  endproperty
  a_soak_range: assert property (p_soak_range) else $error("soak setting too large");
  property p_sf_gate;
    !ctrl_q.framed |=> !o_signal_fail;
  endproperty
  a_sf_gate: assert property (p_sf_gate) else $error("fail flag unframed");
  property p_sd_gate;
    !ctrl_q.framed |=> !o_signal_degrade;
  endproperty
  a_sd_gate: assert property (p_sd_gate) else $error("degrade flag unframed");
  property p_sel_range;
    ctrl_q.sf_sel != 2'h3 && ctrl_q.sd_sel != 2'h3;
  endproperty
  a_sel_range: assert property (p_sel_range) else $error("threshold select out of range");
  property p_soak_restart;
    ctrl_q.soak_arm && !in_service_q && loss_sync_q |=> step_q == 8'h0 && tick_q == 40'h0;
  endproperty
  a_soak_restart: assert property (p_soak_restart) else $error("soak not restarted");
  property p_restart_in_loss;
    ctrl_q.mode == MODE_MANUAL && loss_sync_q && restart_q |=> !o_laser_on;
  endproperty
  a_restart_in_loss: assert property (p_restart_in_loss) else $error("restart during loss");
  c_cov_manual: cover property (
    ctrl_q.mode == MODE_MANUAL && !o_laser_on ##1 restart_q ##1 o_laser_on);
  c_cov_service: cover property ($rose(o_in_service));
  c_cov_irq: cover property ($rose(o_irq));
endmodule : laser_shutdown_soak_ber_control
`default_nettype wire

// File: design/laser_soak_regs.svh
`ifndef LASER_SOAK_REGS_SVH
`define LASER_SOAK_REGS_SVH
// Register byte offsets
`define REG_CTRL 8'h00
`define REG_SOAK 8'h04
`define REG_CMD 8'h08
`define REG_STATUS 8'h0C
`define REG_IRQ_STAT 8'h10
`define REG_IRQ_MASK 8'h14
// Field positions
`define CMD_RESTART_BIT 0
`define IRQ_LOSS_BIT 0
`define IRQ_IN_SERVICE_BIT 1
`define IRQ_SF_BIT 2
`define IRQ_SD_BIT 3
// Reset values
`define CTRL_RESET 8'h00
`define SOAK_RESET 8'h00
`define IRQ_MASK_RESET 4'h0
// Timing
`define CLK_MHZ 200
`define SOAK_STEP_MINUTES 15
`define SOAK_MAX_HOURS 48
`define SOAK_MAX_STEPS (`SOAK_MAX_HOURS * 60 / `SOAK_STEP_MINUTES)
// Threshold exponents of the coarsest choice and the largest selection code
`define SF_BASE_EXP 4'h3
`define SD_BASE_EXP 4'h5
`define SEL_MAX 2'h2
`endif

// File: design/laser_soak_pkg.sv
package laser_soak_pkg;
  typedef enum logic [1:0] {
    MODE_DISABLED = 2'b00,
    MODE_AUTO = 2'b01,
    MODE_MANUAL = 2'b10,
    MODE_TEST = 2'b11
  } laser_mode_type;

  typedef enum logic {
    LASER_OFF = 1'b0,
    LASER_ON = 1'b1
  } laser_state_type;

  typedef struct packed {
    logic [1:0] sd_sel;
    logic [1:0] sf_sel;
    logic framed;
    logic soak_arm;
    laser_mode_type mode;
  } ctrl_type;

  typedef struct packed {
    logic sd;
    logic sf;
    logic loss;
    logic in_service;
    logic laser_on;
  } status_type;
endpackage : laser_soak_pkg

// File: sim/line_model.sv
`timescale 1ns/100ps
`default_nettype none
module line_model (
  // Clock
  input wire logic i_clk,
  // Requests from the bench
  input wire logic i_loss_req,
  input wire logic [3:0] i_exp_req,
  // Line conditions
  output logic o_signal_loss,
  output logic [3:0] o_ber_exp
);
  // Line starts clean
  initial begin
    o_signal_loss = 1'b0;
    o_ber_exp = 4'h0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Line reacts one cycle after a request
  always @(posedge i_clk) begin
    o_signal_loss <= i_loss_req;
    o_ber_exp <= i_exp_req;
  end
endmodule : line_model
`default_nettype wire

// File: sim/tb.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) checks_done++; if ((g) !== (e)) begin $display("ERROR %s expected %0h seen %0h", nm, e, g); bad_count++; end
module tb;
  logic i_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic loss_req = 1'b0;
  logic [3:0] exp_req = 4'h0;
  logic signal_loss;
  logic [3:0] ber_exp;
  logic laser_on, in_service, sig_fail, sig_deg, irq;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  int bad_count = 0;
  int checks_done = 0;
  int seed = 12773;
  logic irq_e = 1'b0;
  logic lz = 1'b1;
  logic [36:0] notes[$];
  logic [1:0] wnotes[$];

  always #2.5 i_clk = ~i_clk;

  line_model i_line_model (.i_clk(i_clk), .i_loss_req(loss_req), .i_exp_req(exp_req),
    .o_signal_loss(signal_loss), .o_ber_exp(ber_exp));

  laser_shutdown_soak_ber_control #(.STEP_CYCLES(64'd4)) i_laser_shutdown_soak_ber_control (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_signal_loss(signal_loss), .i_ber_exp(ber_exp),
    .o_laser_on(laser_on), .o_in_service(in_service), .o_signal_fail(sig_fail),
    .o_signal_degrade(sig_deg), .o_irq(irq), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  ////////////////////////////////////////////////////////////////////////////
  // Closing report
  task automatic stop_test;
    $display("Comparisons %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : stop_test

  task automatic hang;
    bad_count++;
    $display("ERROR handshake expected 1 seen 0");
    stop_test();
  endtask : hang

  task automatic cyc(input int k);
    repeat (k) @(posedge i_clk);
  endtask : cyc

  ////////////////////////////////////////////////////////////////////////////
  // Register bus master
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    logic bv;
    n = 0;
    bv = 1'b0;
    wnotes.push_back((a > 8'h14) ? 2'b10 : 2'b00);
    @(posedge i_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge i_clk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      bv = bvalid;
    end while (!bv && n < 64);
    bready <= 1'b0;
    if (!bv) hang();
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] d);
    int n;
    logic rv;
    n = 0;
    rv = 1'b0;
    notes.push_back({a == 8'h0C, irq_e, lz, (a > 8'h14) ? 2'b10 : 2'b00, d});
    @(posedge i_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge i_clk);
      n++;
      if (arready) arvalid <= 1'b0;
      rv = rvalid;
    end while (!rv && n < 64);
    rready <= 1'b0;
    if (!rv) hang();
  endtask : rd

  ////////////////////////////////////////////////////////////////////////////
  // Result watcher
  always @(posedge i_clk) begin
    logic [36:0] e;
    logic [1:0] eb;
    if (rvalid && rready) begin
      e = notes.pop_front();
      `CHK("read", e[35:0], {irq, laser_on, rresp, rdata})
      if (e[36]) begin
        `CHK("pins", {e[4], e[3], e[1]}, {sig_deg, sig_fail, in_service})
      end
    end
    if (bvalid && bready) begin
      eb = wnotes.pop_front();
      `CHK("bresp", eb, bresp)
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    logic [3:0] e;
    cyc(6);
    i_reset_n <= 1'b1;
    rd(8'h00, 32'h0);
    rd(8'h04, 32'h0);
    rd(8'h14, 32'h0);
    rd(8'h08, 32'h0);
    rd(8'h18, 32'h0);
    wr(8'h18, 32'hFF);
    rd(8'h00, 32'h0);
    loss_req <= 1'b1;
    cyc(6);
    rd(8'h0C, 32'h05);
    rd(8'h10, 32'h01);
    wr(8'h00, 32'h01);
    lz = 1'b0;
    rd(8'h0C, 32'h04);
    loss_req <= 1'b0;
    cyc(6);
    lz = 1'b1;
    rd(8'h0C, 32'h01);
    wr(8'h00, 32'h02);
    loss_req <= 1'b1;
    cyc(6);
    lz = 1'b0;
    wr(8'h08, 32'h01);
    cyc(3);
    rd(8'h0C, 32'h04);
    loss_req <= 1'b0;
    cyc(6);
    rd(8'h0C, 32'h00);
    wr(8'h00, 32'h03);
    cyc(3);
    rd(8'h0C, 32'h00);
    wr(8'h08, 32'h01);
    cyc(3);
    lz = 1'b1;
    rd(8'h0C, 32'h01);
    loss_req <= 1'b1;
    cyc(6);
    rd(8'h0C, 32'h05);
    loss_req <= 1'b0;
    cyc(6);
    // Soak with a loss in mid count
    wr(8'h04, 32'hFF);
    rd(8'h04, 32'hC0);
    wr(8'h04, 32'h03);
    wr(8'h10, 32'h0F);
    wr(8'h14, 32'h02);
    wr(8'h00, 32'h04);
    cyc(4);
    loss_req <= 1'b1;
    cyc(6);
    loss_req <= 1'b0;
    cyc(6);
    rd(8'h0C, 32'h01);
    cyc(25);
    irq_e = 1'b1;
    rd(8'h0C, 32'h03);
    rd(8'h10, 32'h03);
    wr(8'h10, 32'h02);
    irq_e = 1'b0;
    rd(8'h10, 32'h01);
    wr(8'h14, 32'h00);
    // Threshold selections with random rates
    for (int s = 0; s < 3; s++) begin
      wr(8'h00, 32'(s * 8'h50 + 8'h08));
      repeat (4) begin
        e = 4'($random(seed));
        exp_req <= e;
        cyc(4);
        rd(8'h0C, {27'h0, e != 0 && e <= 5 + s, e != 0 && e <= 3 + s, 3'h1});
      end
    end
    wr(8'h00, 32'hF8);
    rd(8'h00, 32'hA8);
    wr(8'h00, 32'h00);
    exp_req <= 4'h1;
    cyc(4);
    rd(8'h0C, 32'h01);
    stop_test();
  end
endmodule : tb
`default_nettype wire
